/* File: logic/igd_map.svh */
// register offsets, field positions and reset values of the gating block
`ifndef IGD_MAP_SVH
`define IGD_MAP_SVH

// ==========================================================================
// apb register byte addresses
`define IGD_ADDR_GATE 12'h000
`define IGD_ADDR_ECP 12'h004
`define IGD_ADDR_PWR 12'h008
`define IGD_ADDR_FMODE 12'h0E0
// option register index; its byte address is four times the index
`define IGD_IDX_FOPT 8'hF1
`define IGD_ADDR_FOPT 12'h3C4
`define IGD_ADDR_ISTAT 12'h010
`define IGD_ADDR_IMASK 12'h014
`define IGD_ADDR_PINS 12'h018

// ==========================================================================
// gate register fields
`define IGD_GATE_FDMA 0
`define IGD_GATE_SER1 1
`define IGD_GATE_SER2 2
`define IGD_GATE_PIRQ 3
`define IGD_GATE_ECPDMA 4
// enable register fields (activate bits, floppy power-down and ecp mode enable)
`define IGD_PWR_FDC 0
`define IGD_PWR_SER1 1
`define IGD_PWR_SER2 2
`define IGD_PWR_PAR 3
`define IGD_PWR_FDC_DOWN 4
`define IGD_PWR_ECP 5

// ==========================================================================
// floppy mode and option fields
`define IGD_FM_ENH2 0
`define IGD_FM_NOBURST 1
`define IGD_FM_IF_HI 3
`define IGD_FM_IF_LO 2
`define IGD_FM_SWAP 4
`define IGD_FM_PUSHPULL 6
`define IGD_FM_TRISTATE 7
`define IGD_FO_DEN_HI 3
`define IGD_FO_DEN_LO 2

// ==========================================================================
// reset values and write masks
`define IGD_FMODE_RST 8'h0E
`define IGD_FOPT_RST 8'h00
`define IGD_FMODE_WMASK 8'hDF
`define IGD_FOPT_WMASK 8'h0C
`define IGD_GATE_RST 8'h00
`define IGD_PWR_RST 8'h00
`define IGD_ECP_RST 8'h00

`endif

/* File: logic/igd_pkg.sv */
// types of the interrupt and dma gating block
package igd_pkg;
    typedef enum logic [2:0] {
        IGD_ECP_PRINTER, IGD_ECP_SPP, IGD_ECP_FIFO, IGD_ECP_ECP,
        IGD_ECP_EPP, IGD_ECP_RES, IGD_ECP_TEST, IGD_ECP_CONFIG
    } igd_ecp_mode_t;

    typedef enum logic [1:0] {
        IGD_IF_ALT3, IGD_IF_ALT2, IGD_IF_RESV, IGD_IF_AT
    } igd_if_mode_t;

    // raw requests from the logical devices
    typedef struct packed {
        logic fdc_irq;
        logic fdc_drq;
        logic fdc_dack_in;
        logic ser1_irq;
        logic ser2_irq;
        logic par_irq;
        logic par_drq;
    } igd_req_t;

    // gated pins: value plus output enable, and the accepted floppy dma request
    typedef struct packed {
        logic fdc_irq;
        logic fdc_irq_oe;
        logic fdc_dack;
        logic fdc_dack_oe;
        logic fdc_drq_acc;
        logic ser1_irq;
        logic ser1_irq_oe;
        logic ser2_irq;
        logic ser2_irq_oe;
        logic par_irq;
        logic par_irq_oe;
        logic par_drq;
        logic par_drq_oe;
    } igd_pins_t;

    typedef struct packed {
        logic [7:0] gate;
        logic [7:0] ecp;
        logic [7:0] pwr;
        logic [7:0] fmode;
        logic [7:0] fopt;
        logic [4:0] istat;
        logic [4:0] imask;
        logic [6:0] req_sync1;
        logic [6:0] req_sync2;
        logic [4:0] pin_prev;
        igd_pins_t pins;
        logic [31:0] prdata;
    } igd_state_t;
endpackage

/* File: logic/igd_gate.sv */
// interrupt and dma gating with floppy mode and option registers
// ==========================================================================
// Behaviour
// - a device register bit disabling irq or dack disables that output
// - floppy dma gate bit zero floats floppy irq and dack, ignores dreq
// - floppy powered down or disabled holds its irq and dack floating
// - serial irq gate bit zero floats that serial port's interrupt
// - in spp and epp modes parallel irq gate zero floats parallel irq
// - ecp modes: dma gated by ecp gate; irq on for 010,011,110
// - floppy config registers reset only on hard reset, not soft reset
// - floppy mode bit 0 selects enhanced floppy mode 2
// - floppy mode bit 1: 0 burst dma, 1 non-burst (default)
// - mode bits 3:2 select interface personality, 11 at default
// - mode bit 4 set swaps drive selects and motor enables 0 and 1
// - mode bit 6: 0 open-drain outputs, 1 push-pull outputs
// - mode bit 7: 0 outputs active, 1 outputs tri-stated
// - bits 6 and 7 leave parallel-port-routed floppy pins untouched
// - option bits 3:2 density: 00 normal, 10 force 1, 11 force 0
// - irq and dma pins float when no logical device selects them
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "igd_map.svh"

module igd_gate
    import igd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire igd_req_t req_in,
    input wire logic fdc_density_in,
    input wire logic [1:0] fdc_drv_sel_in,
    input wire logic [1:0] fdc_motor_in,
    input wire logic fdc_pp_route,
    output igd_pins_t pins,
    output logic [1:0] fdc_drv_sel,
    output logic [1:0] fdc_motor,
    output logic [1:0] fdc_drv_sel_oe,
    output logic [1:0] fdc_motor_oe,
    output logic fdc_density,
    output logic fdc_density_oe,
    output logic fdc_enh_mode2,
    output logic fdc_dma_burst,
    output igd_if_mode_t fdc_if_mode,
    output logic irq
);

    igd_state_t s_q, s_d;

    // ======================================================================
    // helpers
    function automatic logic ecp_irq_on(input logic [2:0] m);
        return m == IGD_ECP_FIFO || m == IGD_ECP_ECP || m == IGD_ECP_TEST;
    endfunction

    // open drain drives only the low level; push-pull drives both
    function automatic logic od_oe(input logic v, input logic pp,
                                   input logic en);
        return en && (pp || !v);
    endfunction

    logic wr, rd, hit;
    logic [31:0] rmux;
    logic [6:0] rq;
    logic fdc_on, fdc_gate, ser1_on, ser2_on, par_on;
    logic pp, tri_fdc, swap;
    logic [4:0] lvl, rise;

    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign prdata = s_q.prdata;
    assign pins = s_q.pins;
    assign irq = |(s_q.istat & s_q.imask);

    always_comb begin
        hit = 1'b1;
        case (paddr)
            `IGD_ADDR_GATE: rmux = {24'h000000, s_q.gate};
            `IGD_ADDR_ECP: rmux = {24'h000000, s_q.ecp};
            `IGD_ADDR_PWR: rmux = {24'h000000, s_q.pwr};
            `IGD_ADDR_FMODE: rmux = {24'h000000, s_q.fmode};
            `IGD_ADDR_FOPT: rmux = {24'h000000, s_q.fopt};
            `IGD_ADDR_ISTAT: rmux = {27'h0000000, s_q.istat};
            `IGD_ADDR_IMASK: rmux = {27'h0000000, s_q.imask};
            `IGD_ADDR_PINS: rmux = {27'h0000000, lvl};
            default: begin
                rmux = 32'h00000000;
                hit = 1'b0;
            end
        endcase
    end
    assign pslverr = psel && penable && !hit;

    // ======================================================================
    // gating decisions
    always_comb begin
        rq = s_q.req_sync2;
        // activate bit plus in-block gate (parallel irq needs no gate in ecp modes 010,011,110), floppy also needs power
        fdc_on = s_q.pwr[`IGD_PWR_FDC]
            && !s_q.pwr[`IGD_PWR_FDC_DOWN];
        fdc_gate = fdc_on && s_q.gate[`IGD_GATE_FDMA];
        ser1_on = s_q.pwr[`IGD_PWR_SER1] && s_q.gate[`IGD_GATE_SER1];
        ser2_on = s_q.pwr[`IGD_PWR_SER2] && s_q.gate[`IGD_GATE_SER2];
        if (s_q.pwr[`IGD_PWR_ECP]) begin
            par_on = ecp_irq_on(s_q.ecp[2:0])
                || s_q.gate[`IGD_GATE_PIRQ];
        end else begin
            par_on = s_q.gate[`IGD_GATE_PIRQ];
        end
        par_on = par_on && s_q.pwr[`IGD_PWR_PAR];
        pp = s_q.fmode[`IGD_FM_PUSHPULL];
        tri_fdc = s_q.fmode[`IGD_FM_TRISTATE]
            && !fdc_pp_route;
        swap = s_q.fmode[`IGD_FM_SWAP];
        lvl = {rq[6], rq[3], rq[2], rq[1], rq[0]};
    end
    assign rise = lvl & ~s_q.pin_prev;

    // floppy drive outputs, unaffected by output control when routed
    // through the parallel port pins
    always_comb begin
        fdc_drv_sel = swap ? {fdc_drv_sel_in[0], fdc_drv_sel_in[1]}
                           : fdc_drv_sel_in;
        fdc_motor = swap ? {fdc_motor_in[0], fdc_motor_in[1]}
                         : fdc_motor_in;
        for (int i = 0; i < 2; i++) begin
            fdc_drv_sel_oe[i] = fdc_pp_route ? 1'b1
                : od_oe(fdc_drv_sel[i], pp, !tri_fdc);
            fdc_motor_oe[i] = fdc_pp_route ? 1'b1
                : od_oe(fdc_motor[i], pp, !tri_fdc);
        end
        case (s_q.fopt[`IGD_FO_DEN_HI:`IGD_FO_DEN_LO])
            2'b10: fdc_density = 1'b1;
            2'b11: fdc_density = 1'b0;
            default: fdc_density = fdc_density_in;
        endcase
        fdc_density_oe = fdc_pp_route ? 1'b1
            : od_oe(fdc_density, pp, !tri_fdc);
        fdc_enh_mode2 = s_q.fmode[`IGD_FM_ENH2];
        fdc_dma_burst = !s_q.fmode[`IGD_FM_NOBURST];
        fdc_if_mode = igd_if_mode_t'(
            s_q.fmode[`IGD_FM_IF_HI:`IGD_FM_IF_LO]);
    end

    // ======================================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.req_sync1 = req_in;
        s_d.req_sync2 = s_q.req_sync1;
        s_d.pin_prev = lvl;
        s_d.prdata = rd ? rmux : s_q.prdata;
        // soft reset clears run-time gates but never floppy config
        if (soft_reset) begin
            s_d.gate = `IGD_GATE_RST;
            s_d.ecp = `IGD_ECP_RST;
            s_d.pwr = `IGD_PWR_RST;
        end else if (wr) begin
            case (paddr)
                `IGD_ADDR_GATE: s_d.gate = pwdata[7:0];
                `IGD_ADDR_ECP: s_d.ecp = pwdata[7:0];
                `IGD_ADDR_PWR: s_d.pwr = pwdata[7:0];
                `IGD_ADDR_IMASK: s_d.imask = pwdata[4:0];
                default: ;
            endcase
        end
        // reserved bits stay zero even if software slips
        if (wr && paddr == `IGD_ADDR_FMODE) begin
            s_d.fmode = pwdata[7:0] & `IGD_FMODE_WMASK;
        end
        if (wr && paddr == `IGD_ADDR_FOPT) begin
            s_d.fopt = pwdata[7:0] & `IGD_FOPT_WMASK;
        end
        // read clears status; a new edge in the same cycle wins
        if (rd && paddr == `IGD_ADDR_ISTAT) begin
            s_d.istat = 5'h00;
        end
        s_d.istat = s_d.istat | rise;

        s_d.pins.fdc_irq = rq[6];
        s_d.pins.fdc_irq_oe = fdc_gate;
        s_d.pins.fdc_dack = rq[4];
        s_d.pins.fdc_dack_oe = fdc_gate;
        s_d.pins.fdc_drq_acc = fdc_gate && rq[5];
        s_d.pins.ser1_irq = rq[3];
        s_d.pins.ser1_irq_oe = ser1_on;
        s_d.pins.ser2_irq = rq[2];
        s_d.pins.ser2_irq_oe = ser2_on;
        s_d.pins.par_irq = rq[1];
        s_d.pins.par_irq_oe = par_on;
        s_d.pins.par_drq = rq[0];
        s_d.pins.par_drq_oe = s_q.pwr[`IGD_PWR_PAR]
            && s_q.pwr[`IGD_PWR_ECP]
            && s_q.gate[`IGD_GATE_ECPDMA];
    end

    // ======================================================================
    // presetn is the hard reset: power-on or host reset line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.fmode <= `IGD_FMODE_RST;
            s_q.fopt <= `IGD_FOPT_RST;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

/* File: tb/igd_gate_monitor.sv */
// port assertions for the interrupt and dma gating block
`timescale 1ns/10ps
module igd_gate_monitor
    import igd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    input wire igd_req_t req_in,
    input wire logic [1:0] fdc_drv_sel_in,
    input wire igd_pins_t pins,
    input wire logic [1:0] fdc_drv_sel
);
    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    // two sync flops plus the output register: three edges
    a_ser1_path: assert property (pins.ser1_irq_oe |->
        pins.ser1_irq == $past(req_in.ser1_irq, 3)) else $error("ser1 irq");
    a_ser2_path: assert property (pins.ser2_irq_oe |->
        pins.ser2_irq == $past(req_in.ser2_irq, 3)) else $error("ser2 irq");
    a_fdc_irq_path: assert property (pins.fdc_irq_oe |->
        pins.fdc_irq == $past(req_in.fdc_irq, 3)) else $error("fdc irq");
    a_par_irq_path: assert property (pins.par_irq_oe |->
        pins.par_irq == $past(req_in.par_irq, 3)) else $error("par irq");
    a_fdc_oe_pair: assert property (pins.fdc_dack_oe ==
        pins.fdc_irq_oe) else $error("fdc irq and dack enables differ");
    a_slverr_in_access: assert property (pslverr |-> acc)
        else $error("slave error outside access phase");
    a_drv_swap_only: assert property (fdc_drv_sel == fdc_drv_sel_in
        || fdc_drv_sel == {fdc_drv_sel_in[0], fdc_drv_sel_in[1]})
        else $error("drive select neither direct nor swapped");
    // oe moves two edges after the write: register, then pin flop
    a_oe_by_write: assert property ($changed(pins.ser1_irq_oe) |->
        $past(acc && pwrite, 2) || $past(soft_reset, 2))
        else $error("ser1 oe moved");
    c_refused: cover property (acc && pslverr);
    c_par_irq_on: cover property (pins.par_irq_oe);
    c_ser1_rise: cover property ($rose(pins.ser1_irq));
endmodule

bind igd_gate igd_gate_monitor mon (.pclk, .presetn, .soft_reset, .psel,
    .penable, .pwrite, .pslverr, .req_in, .fdc_drv_sel_in, .pins,
    .fdc_drv_sel);

/* File: tb/igd_host_model.sv */
// far-side model: request sources and the resolved serial irq wire
`timescale 1ns/10ps
module igd_host_model
    import igd_pkg::*;
(
    input wire logic pclk,
    input wire igd_req_t want,
    input wire igd_pins_t pins,
    output igd_req_t req,
    output logic ser1_wire
);
    logic last_q = 1'b0;
    // ==========================================================
    // requests move just after the edge, like a real source
    always_ff @(posedge pclk) begin
        req <= want;
        if (pins.ser1_irq_oe) begin
            last_q <= pins.ser1_irq;
        end
    end
    // a floated line shows the inverse of its last value, never a copy
    assign ser1_wire = pins.ser1_irq_oe ? pins.ser1_irq : ~last_q;
endmodule

/* File: tb/irq_dma_gating_and_fdc_config_tb.sv */
// self-checking bench for the gating and floppy config block
`timescale 1ns/10ps
`include "igd_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module irq_dma_gating_and_fdc_config_tb
    import igd_pkg::*;
;
    logic pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic err_q, fdc_density_in, fdc_pp_route, fdc_density, fdc_density_oe;
    logic [1:0] fdc_drv_sel_in, fdc_motor_in, fdc_drv_sel, fdc_motor;
    logic [1:0] fdc_drv_sel_oe, fdc_motor_oe;
    logic fdc_enh_mode2, fdc_dma_burst, irq, ser1_wire;
    igd_if_mode_t fdc_if_mode;
    igd_req_t req_in, want;
    igd_pins_t pins;
    int num_errors = 0;
    int cmp_count = 0;
    // ==========================================================
    // design and far side
    igd_gate dut (.pclk, .presetn, .soft_reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .req_in,
        .fdc_density_in, .fdc_drv_sel_in, .fdc_motor_in, .fdc_pp_route,
        .pins, .fdc_drv_sel, .fdc_motor, .fdc_drv_sel_oe, .fdc_motor_oe,
        .fdc_density, .fdc_density_oe, .fdc_enh_mode2, .fdc_dma_burst,
        .fdc_if_mode, .irq);
    igd_host_model host (.pclk, .want, .pins, .req(req_in), .ser1_wire);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================================
    // apb master: called just after an edge, ends on an edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        rd_q = prdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (5) @(posedge pclk); // covers sync and output registers
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd_q, e)
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        tally_and_finish;
    end
    // ==========================================================
    // tests
    localparam logic [7:0] OT_MODE [4] = '{8'h00, 8'h40, 8'hC0, 8'hC0};
    localparam logic [1:0] OT_EXP [4] = '{2'h2, 2'h3, 2'h0, 2'h3};
    initial begin
        {presetn, soft_reset, psel, penable, pwrite, fdc_pp_route} = '0;
        {paddr, pwdata, fdc_density_in, fdc_drv_sel_in, fdc_motor_in} = '0;
        want = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_rd(`IGD_ADDR_FMODE, 32'h0000000E);
        chk_rd(`IGD_ADDR_FOPT, 32'h00000000);
        `CHK(fdc_dma_burst, 1'b0)
        `CHK(fdc_if_mode, IGD_IF_AT)
        `CHK(fdc_enh_mode2, 1'b0)
        wr(`IGD_ADDR_FMODE, 32'h000000FF);
        chk_rd(`IGD_ADDR_FMODE, 32'h000000DF);
        fdc_drv_sel_in <= 2'h1;
        fdc_motor_in <= 2'h2;
        wr(`IGD_ADDR_FMODE, 32'h00000011);
        `CHK(fdc_enh_mode2, 1'b1)
        `CHK(fdc_dma_burst, 1'b1)
        `CHK(fdc_drv_sel, 2'h2)
        `CHK(fdc_motor, 2'h1)
        for (int i = 0; i < 4; i++) begin
            wr(`IGD_ADDR_FMODE, 32'(i << 2));
            `CHK(fdc_if_mode, igd_if_mode_t'(i[1:0]))
            fdc_pp_route <= (i == 3);
            wr(`IGD_ADDR_FMODE, {24'h0, OT_MODE[i]});
            `CHK(fdc_drv_sel_oe, OT_EXP[i])
            `CHK(fdc_motor_oe, {OT_EXP[i][0], OT_EXP[i][1]})
            fdc_density_in <= i[0];
            wr(`IGD_ADDR_FOPT, 32'(i << 2)); // reserved bits kept zero
            `CHK(fdc_density, (i == 2) | (i != 3 && i[0]))
            `CHK(fdc_density_oe, i != 2)
        end
        want.fdc_drq <= 1'b1;
        wr(`IGD_ADDR_PWR, 32'h0000000F);
        `CHK({pins.ser1_irq_oe, pins.fdc_irq_oe}, 2'h0)
        `CHK(pins.fdc_drq_acc, 1'b0)
        wr(`IGD_ADDR_GATE, 32'h0000001F);
        `CHK({pins.ser1_irq_oe, pins.ser2_irq_oe}, 2'h3)
        `CHK({pins.fdc_irq_oe, pins.fdc_drq_acc}, 2'h3)
        wr(`IGD_ADDR_IMASK, 32'h0000001F);
        want.ser1_irq <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK({ser1_wire, irq}, 2'h3)
        chk_rd(`IGD_ADDR_ISTAT, 32'h00000008);
        chk_rd(`IGD_ADDR_ISTAT, 32'h00000000);
        wr(`IGD_ADDR_IMASK, 32'h00000000);
        want.ser2_irq <= 1'b1;
        wr(`IGD_ADDR_PWR, 32'h0000001F);
        `CHK({irq, pins.fdc_irq_oe}, 2'h0)
        chk_rd(`IGD_ADDR_ISTAT, 32'h00000004);
        chk_rd(`IGD_ADDR_PINS, 32'h0000000C);
        wr(`IGD_ADDR_GATE, 32'h00000010);
        `CHK(ser1_wire, 1'b0)
        wr(`IGD_ADDR_PWR, 32'h00000028);
        for (int m = 0; m < 8; m++) begin
            wr(`IGD_ADDR_ECP, 32'(m));
            `CHK(pins.par_irq_oe, (m == 2 || m == 3 || m == 6))
            `CHK(pins.par_drq_oe, 1'b1)
        end
        wr(`IGD_ADDR_GATE, 32'h00000008);
        `CHK({pins.par_drq_oe, pins.par_irq_oe}, 2'h1)
        wr(`IGD_ADDR_PWR, 32'h00000008);
        `CHK(pins.par_irq_oe, 1'b1)
        wr(`IGD_ADDR_GATE, 32'h00000000);
        `CHK(pins.par_irq_oe, 1'b0)
        wr(`IGD_ADDR_PWR, 32'h00000000);
        `CHK({pins.ser2_irq_oe, pins.fdc_dack_oe}, 2'h0)
        wr(`IGD_ADDR_FMODE, 32'h0000005C);
        wr(`IGD_ADDR_GATE, 32'h0000001F);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        chk_rd(`IGD_ADDR_GATE, 32'h00000000);
        chk_rd(`IGD_ADDR_FMODE, 32'h0000005C);
        apb(1'b0, 12'h01C, 32'h00000000);
        `CHK({err_q, rd_q}, 33'h100000000)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_rd(`IGD_ADDR_FMODE, 32'h0000000E);
        tally_and_finish;
    end
endmodule
